//--- verilog/hbp_regs.svh
// register codes, field positions, reset values and sizes of the buffer word port
`ifndef HBP_REGS_SVH
`define HBP_REGS_SVH
`define HBP_CMD_ISO0_LEN    8'h2d
`define HBP_CMD_ISO1_LEN    8'h2e
`define HBP_CMD_ISO_RD      8'h40
`define HBP_CMD_ASYNC_RD    8'h41
`define HBP_CMD_ISO_WR      8'hc0
`define HBP_CMD_ASYNC_WR    8'hc1
`define HBP_CMD_COUNT_WR    8'ha2
`define HBP_CMD_STATUS_RD   8'h2c
`define HBP_CMD_IRQ_RD      8'h24
`define HBP_RAM_BYTES       4096
`define HBP_ISO_BASE        12'h000
`define HBP_ISO1_BASE       12'h400
`define HBP_ASYNC_BASE      12'h800
`define HBP_EOT_BIT         2
`define HBP_ST_ISO0_FULL    0
`define HBP_ST_ISO1_FULL    1
`define HBP_ST_ASYNC_FULL   2
`define HBP_ST_ISO0_DONE    3
`define HBP_ST_ISO1_DONE    4
`define HBP_ST_ASYNC_DONE   5
`define HBP_RESET_WORD      16'h0000
`define HBP_AXI_CMD         5'h00
`define HBP_AXI_WDATA       5'h04
`define HBP_AXI_RDATA       5'h08
`define HBP_AXI_STAT        5'h0c
`endif

//--- verilog/hbp_pkg.sv
// types shared by both ends of the buffer word port
package hbp_pkg;
  typedef logic [7:0]  hbp_cmd_t;
  typedef logic [15:0] hbp_word_t;
  typedef enum logic [1:0] {
    HBP_IDLE = 2'b00,
    HBP_ISO  = 2'b01,
    HBP_ASY  = 2'b10
  } hbp_port_t;
endpackage

//--- verilog/hbp_if.sv
// command and word channel between host driver and buffer word port
interface hbp_if;
  logic              cmd_valid;   // command strobe
  logic              cmd_ready;   // command accepted
  hbp_pkg::hbp_cmd_t cmd;         // command code
  logic              wr_valid;    // write word offered
  logic              wr_ready;    // write word taken
  hbp_pkg::hbp_word_t wr_data;    // write word
  logic              rd_valid;    // read word offered
  logic              rd_ready;    // read word taken
  hbp_pkg::hbp_word_t rd_data;    // read word
  modport dev  (input cmd_valid, cmd, wr_valid, wr_data, rd_ready,
                output cmd_ready, wr_ready, rd_valid, rd_data);
  modport host (output cmd_valid, cmd, wr_valid, wr_data, rd_ready,
                input cmd_ready, wr_ready, rd_valid, rd_data);
endinterface

//--- verilog/hbp_skid.sv
// two-entry buffer with valid and ready on both sides
`include "hbp_regs.svh"
module hbp_skid (
  input  wire logic              sys_clk,   // clock
  input  wire logic              rst,       // async reset
  input  wire logic              in_valid,  // word offered
  output logic                   in_ready,  // room left
  input  wire hbp_pkg::hbp_word_t in_data,  // word in
  output logic                   out_valid, // word held
  input  wire logic              out_ready, // word taken
  output hbp_pkg::hbp_word_t     out_data   // word out
);
  import hbp_pkg::*;
  hbp_word_t  mem_reg [2];
  logic       wp_reg;
  logic       rp_reg;
  logic [1:0] cnt_reg;
  wire        push = in_valid && in_ready;
  wire        pop  = out_valid && out_ready;
  // honest full and empty
  assign in_ready  = cnt_reg != 2'd2;
  assign out_valid = cnt_reg != 2'd0;
  assign out_data  = mem_reg[rp_reg];
  // pointers and count
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'd0;
      mem_reg[0] <= `HBP_RESET_WORD;
      mem_reg[1] <= `HBP_RESET_WORD;
    end else begin
      if (push) begin
        mem_reg[wp_reg] <= in_data;
        wp_reg <= ~wp_reg;
      end
      if (pop) rp_reg <= ~rp_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

//--- verilog/hbp_dev.sv
// device end: buffer ram, pointers, counters, status and read-back lengths
`include "hbp_regs.svh"
// ----------------------------------------------------------------
// functional notes
// ----------------------------------------------------------------
// Functional notes
// - read-only iso buffer 0 pending byte count
// - read-only iso buffer 1 pending byte count
// - driver loads count from read-back length
// - iso port: even byte high, odd low
// - async port: odd byte high, even low
// - iso command once, then whole words
// - async command once, then whole words
// - iso pointer steps two until count
// - async pointer steps two until count
// - reaching count sets eot flag, status
// - driver loads count, checks status first
// - count in bytes, port moves words
// - full and done flag per buffer
// - driver keeps buffer sizes within ram
module hbp_dev (
  input  wire logic              sys_clk,          // clock
  input  wire logic              rst,              // async reset
  hbp_if.dev                     bus,              // driver side
  input  wire logic [15:0]       iso0_fill_bytes,  // bytes landed in iso buffer 0
  input  wire logic [15:0]       iso1_fill_bytes,  // bytes landed in iso buffer 1
  input  wire logic              iso_sel,          // iso buffer 1 selected for port
  output logic [5:0]             buffer_status_flags, // full and done flags
  output logic [15:0]            host_cpu_interrupt_flags // event flags
);
  import hbp_pkg::*;
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]  ram_reg [`HBP_RAM_BYTES];
  hbp_port_t   mode_reg;
  logic        wr_dir_reg;
  logic [11:0] ptr_reg;
  logic [11:0] base_reg;
  logic [15:0] count_reg;
  logic [15:0] iso0_len_reg;
  logic [15:0] iso1_len_reg;
  logic [5:0]  stat_reg;
  logic [15:0] irq_reg;
  logic        cmd_arg_reg;
  hbp_word_t   rd_word;
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire [15:0] offs      = {4'h0, ptr_reg - base_reg};
  wire        at_end    = offs >= count_reg;
  wire        port_on   = mode_reg != HBP_IDLE && !at_end;
  wire        is_iso    = mode_reg == HBP_ISO;
  wire [11:0] ptr_odd   = ptr_reg + 12'd1;
  wire        wr_fire   = bus.wr_valid && bus.wr_ready && !cmd_arg_reg;
  wire        arg_fire  = bus.wr_valid && bus.wr_ready && cmd_arg_reg;
  wire        rd_push   = port_on && !wr_dir_reg;
  wire        rd_take;
  wire        word_done = (wr_fire && port_on && wr_dir_reg) || (rd_push && rd_take);
  wire [15:0] next_offs = offs + 16'd2;
  wire        eot       = word_done && next_offs >= count_reg;
  wire        cmd_fire  = bus.cmd_valid && bus.cmd_ready;
  wire        is_iso_cmd = bus.cmd == `HBP_CMD_ISO_RD || bus.cmd == `HBP_CMD_ISO_WR;
  wire        is_asy_cmd = bus.cmd == `HBP_CMD_ASYNC_RD || bus.cmd == `HBP_CMD_ASYNC_WR;
  wire [11:0] iso_base  = iso_sel ? `HBP_ISO1_BASE : `HBP_ISO_BASE;
  assign bus.cmd_ready = !cmd_arg_reg;
  assign bus.wr_ready  = cmd_arg_reg || (port_on && wr_dir_reg);
  // byte order differs per port
  assign rd_word = is_iso ? {ram_reg[ptr_reg], ram_reg[ptr_odd]}
                          : {ram_reg[ptr_odd], ram_reg[ptr_reg]};
  // register reads answer through the same word buffer
  logic       reg_rd_reg;
  hbp_word_t  reg_word_reg;
  wire        skid_valid = rd_push || reg_rd_reg;
  wire        skid_ready;
  assign rd_take = skid_ready && !reg_rd_reg;
  hbp_skid u_rd_buf (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (skid_valid),
    .in_ready  (skid_ready),
    .in_data   (reg_rd_reg ? reg_word_reg : rd_word),
    .out_valid (bus.rd_valid),
    .out_ready (bus.rd_ready),
    .out_data  (bus.rd_data)
  );
  assign buffer_status_flags      = stat_reg;
  assign host_cpu_interrupt_flags = irq_reg;
  // ----------------------------------------------------------------
  // command, pointer and flag logic
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_reg     <= HBP_IDLE;
      wr_dir_reg   <= 1'b0;
      ptr_reg      <= 12'h000;
      base_reg     <= 12'h000;
      count_reg    <= 16'h0000;
      iso0_len_reg <= 16'h0000;
      iso1_len_reg <= 16'h0000;
      stat_reg     <= 6'h00;
      irq_reg      <= 16'h0000;
      cmd_arg_reg  <= 1'b0;
      reg_rd_reg   <= 1'b0;
      reg_word_reg <= `HBP_RESET_WORD;
    end else begin
      iso0_len_reg <= iso0_fill_bytes;
      iso1_len_reg <= iso1_fill_bytes;
      if (reg_rd_reg && skid_ready) reg_rd_reg <= 1'b0;
      if (arg_fire) begin
        count_reg   <= bus.wr_data;
        cmd_arg_reg <= 1'b0;
      end
      if (word_done) ptr_reg <= ptr_reg + 12'd2;
      if (wr_fire && port_on && wr_dir_reg) begin
        ram_reg[ptr_reg] <= is_iso ? bus.wr_data[15:8] : bus.wr_data[7:0];
        ram_reg[ptr_odd] <= is_iso ? bus.wr_data[7:0] : bus.wr_data[15:8];
      end
      if (eot) begin
        irq_reg[`HBP_EOT_BIT] <= 1'b1;
        mode_reg <= HBP_IDLE;
        if (is_iso) begin
          stat_reg[iso_sel ? `HBP_ST_ISO1_FULL : `HBP_ST_ISO0_FULL] <= wr_dir_reg;
          stat_reg[iso_sel ? `HBP_ST_ISO1_DONE : `HBP_ST_ISO0_DONE] <= !wr_dir_reg;
        end else begin
          stat_reg[`HBP_ST_ASYNC_FULL] <= wr_dir_reg;
          stat_reg[`HBP_ST_ASYNC_DONE] <= !wr_dir_reg;
        end
      end
      if (cmd_fire) begin
        if (is_iso_cmd || is_asy_cmd) begin
          mode_reg   <= is_iso_cmd ? HBP_ISO : HBP_ASY;
          wr_dir_reg <= bus.cmd[7];
          ptr_reg    <= is_iso_cmd ? iso_base : `HBP_ASYNC_BASE;
          base_reg   <= is_iso_cmd ? iso_base : `HBP_ASYNC_BASE;
        end else if (bus.cmd == `HBP_CMD_COUNT_WR) begin
          cmd_arg_reg <= 1'b1;
        end else begin
          reg_rd_reg <= 1'b1;
          unique case (bus.cmd)
            `HBP_CMD_ISO0_LEN:  reg_word_reg <= iso0_len_reg;
            `HBP_CMD_ISO1_LEN:  reg_word_reg <= iso1_len_reg;
            `HBP_CMD_STATUS_RD: reg_word_reg <= {10'h000, stat_reg};
            `HBP_CMD_IRQ_RD: begin
              reg_word_reg <= irq_reg;
              irq_reg <= eot ? 16'h0004 : 16'h0000;            // set wins over clear
            end
            default: reg_word_reg <= `HBP_RESET_WORD;
          endcase
        end
      end
    end
  end
endmodule

//--- verilog/hbp_host.sv
// host end: axi4-lite slave that issues commands and moves words
`include "hbp_regs.svh"
module hbp_host (
  input  wire logic         sys_clk,  // clock
  input  wire logic         rst,      // async reset
  hbp_if.host               bus,      // device side
  input  wire logic [4:0]   awaddr,   // write address
  input  wire logic         awvalid,  // write address valid
  output logic              awready,  // write address ready
  input  wire logic [31:0]  wdata,    // write data
  input  wire logic [3:0]   wstrb,    // byte enables
  input  wire logic         wvalid,   // write data valid
  output logic              wready,   // write data ready
  output logic [1:0]        bresp,    // write response
  output logic              bvalid,   // write response valid
  input  wire logic         bready,   // write response ready
  input  wire logic [4:0]   araddr,   // read address
  input  wire logic         arvalid,  // read address valid
  output logic              arready,  // read address ready
  output logic [31:0]       rdata,    // read data
  output logic [1:0]        rresp,    // read response
  output logic              rvalid,   // read valid
  input  wire logic         rready    // read ready
);
  import hbp_pkg::*;
  logic        aw_reg, w_reg;
  logic [4:0]  awa_reg;
  logic [31:0] wd_reg;
  logic        cmdv_reg, wrv_reg;
  hbp_cmd_t    cmd_reg;
  hbp_word_t   wrd_reg;
  hbp_word_t   rword_reg;
  logic        rfull_reg;
  // both halves of a write held, act once the channel is free
  wire do_wr   = aw_reg && w_reg && !bvalid && !cmdv_reg && !wrv_reg;
  wire hit_cmd = awa_reg == `HBP_AXI_CMD;
  wire hit_wd  = awa_reg == `HBP_AXI_WDATA;
  assign awready = !aw_reg;
  assign wready  = !w_reg;
  assign arready = !rvalid;
  assign bus.cmd_valid = cmdv_reg;
  assign bus.cmd       = cmd_reg;
  assign bus.wr_valid  = wrv_reg;
  assign bus.wr_data   = wrd_reg;
  assign bus.rd_ready  = !rfull_reg;
  assign bresp = 2'b00;
  // axi handshakes and word hand-off
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aw_reg <= 1'b0; w_reg <= 1'b0; awa_reg <= 5'h00; wd_reg <= 32'h0;
      cmdv_reg <= 1'b0; wrv_reg <= 1'b0; cmd_reg <= 8'h00; wrd_reg <= 16'h0000;
      rword_reg <= 16'h0000; rfull_reg <= 1'b0; bvalid <= 1'b0;
      rvalid <= 1'b0; rdata <= 32'h0; rresp <= 2'b00;
    end else begin
      if (awvalid && awready) begin aw_reg <= 1'b1; awa_reg <= awaddr; end
      if (wvalid && wready) begin w_reg <= 1'b1; wd_reg <= wdata; end
      if (do_wr) begin
        aw_reg <= 1'b0; w_reg <= 1'b0; bvalid <= 1'b1;
        if (hit_cmd && wstrb[0]) begin cmdv_reg <= 1'b1; cmd_reg <= wd_reg[7:0]; end
        if (hit_wd) begin wrv_reg <= 1'b1; wrd_reg <= wd_reg[15:0]; end
      end
      if (bvalid && bready) bvalid <= 1'b0;
      if (cmdv_reg && bus.cmd_ready) cmdv_reg <= 1'b0;
      if (wrv_reg && bus.wr_ready) wrv_reg <= 1'b0;
      if (bus.rd_valid && !rfull_reg) begin rfull_reg <= 1'b1; rword_reg <= bus.rd_data; end
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp  <= 2'b00;
        if (araddr == `HBP_AXI_RDATA) begin
          rdata <= {16'h0000, rword_reg};
          rfull_reg <= 1'b0;
        end else if (araddr == `HBP_AXI_STAT)
          rdata <= {29'h0, rfull_reg, wrv_reg, cmdv_reg};
        else begin
          rdata <= 32'h0;
          rresp <= 2'b10;
        end
      end
      if (rvalid && rready) rvalid <= 1'b0;
    end
  end
endmodule

//--- verif/hbp_checker.sv
// concurrent checks on the command and word channel between the two ends
`include "hbp_regs.svh"
module hbp_checker (
  input wire logic               sys_clk,   // clock
  input wire logic               rst,       // async reset
  input wire logic               cmd_valid, // command strobe
  input wire logic               cmd_ready, // command accepted
  input wire hbp_pkg::hbp_cmd_t  cmd,       // command code
  input wire logic               wr_valid,  // write word offered
  input wire logic               wr_ready,  // write word taken
  input wire hbp_pkg::hbp_word_t wr_data,   // write word
  input wire logic               rd_valid,  // read word offered
  input wire logic               rd_ready,  // read word taken
  input wire hbp_pkg::hbp_word_t rd_data    // read word
);
  import hbp_pkg::*;
  // ----------------------------------------------------------------
  // transfer tracking
  // ----------------------------------------------------------------
  logic        due_reg;   // next write word is the byte count
  logic [1:0]  mode_reg;  // 1 port write, 2 port read
  logic [15:0] count_reg; // byte count in force
  logic [15:0] words_reg; // words moved since the port command
  // handshakes and command decode
  wire logic cmd_take = cmd_valid && cmd_ready;
  wire logic wr_take  = wr_valid && wr_ready;
  wire logic rd_take  = rd_valid && rd_ready && (mode_reg == 2'd2);
  wire logic is_wr    = (cmd == `HBP_CMD_ISO_WR) || (cmd == `HBP_CMD_ASYNC_WR);
  wire logic is_rd    = (cmd == `HBP_CMD_ISO_RD) || (cmd == `HBP_CMD_ASYNC_RD);
  wire logic is_reg   = (cmd == `HBP_CMD_ISO0_LEN) || (cmd == `HBP_CMD_ISO1_LEN)
                     || (cmd == `HBP_CMD_STATUS_RD) || (cmd == `HBP_CMD_IRQ_RD);
  // follow count load, port mode and words moved
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      due_reg   <= 1'b0;
      mode_reg  <= 2'd0;
      count_reg <= 16'h0000;
      words_reg <= 16'h0000;
    end else if (cmd_take) begin
      due_reg   <= (cmd == `HBP_CMD_COUNT_WR);
      mode_reg  <= is_wr ? 2'd1 : (is_rd ? 2'd2 : 2'd0);
      words_reg <= 16'h0000;
    end else if (wr_take && due_reg) begin
      due_reg   <= 1'b0;
      count_reg <= wr_data;
    end else if (wr_take || rd_take) begin
      words_reg <= words_reg + 16'h0001;
    end
  end
  default clocking dcb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_cmd_hold: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd))
    else $error("command dropped or changed before taken");
  chk_wr_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
    else $error("write word dropped or changed before taken");
  chk_rd_hold: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
    else $error("read word dropped or changed before taken");
  chk_cmd_legal: assert property (cmd_valid |-> is_wr || is_rd || is_reg
    || cmd == `HBP_CMD_COUNT_WR) else $error("unknown command code sent");
  chk_wr_after_cmd: assert property (wr_valid |-> due_reg || mode_reg == 2'd1)
    else $error("write word without count or write command");
  chk_wr_in_count: assert property (wr_take && !due_reg |-> {words_reg, 1'b0} < count_reg)
    else $error("write word taken past the byte count");
  chk_rd_in_count: assert property (rd_take |-> {words_reg, 1'b0} < count_reg)
    else $error("read word given past the byte count");
  chk_reg_answer: assert property (cmd_take && is_reg |-> ##[1:16] rd_valid)
    else $error("register read command gave no word");
  cov_iso_wr: cover property (cmd_take && cmd == `HBP_CMD_ISO_WR);
  cov_async_rd: cover property (cmd_take && cmd == `HBP_CMD_ASYNC_RD);
  cov_last_rd: cover property (rd_take && {words_reg, 1'b0} + 17'h2 == {1'b0, count_reg});
endmodule

//--- verif/host_buffer_ram_word_port_tb_top.sv
// bench: axi4-lite software on the host end, device end across the channel
`include "hbp_regs.svh"
module host_buffer_ram_word_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import hbp_pkg::*;
  // ----------------------------------------------------------------
  // stimulus signals and instances
  // ----------------------------------------------------------------
  logic        sys_clk   = 1'b0;
  logic        rst       = 1'b1;
  logic [4:0]  awaddr    = 5'h00;
  logic [4:0]  araddr    = 5'h00;
  logic [31:0] wdata     = 32'h0;
  logic [3:0]  wstrb     = 4'hf;
  logic        awvalid   = 1'b0;
  logic        wvalid    = 1'b0;
  logic        bready    = 1'b0;
  logic        arvalid   = 1'b0;
  logic        rready    = 1'b0;
  logic        iso_sel   = 1'b0;
  logic [15:0] iso0_fill_bytes = 16'h0006;
  logic [15:0] iso1_fill_bytes = 16'h000a;
  wire logic   awready, wready, bvalid, arready, rvalid;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [5:0]  stat_flags;
  wire logic [15:0] irq_flags;
  int          bad_count   = 0;
  int          checks_done = 0;
  hbp_if hbp_if_i ();
  hbp_host hbp_host_i (.sys_clk, .rst, .bus(hbp_if_i.host), .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready);
  hbp_dev hbp_dev_i (.sys_clk, .rst, .bus(hbp_if_i.dev), .iso0_fill_bytes,
    .iso1_fill_bytes, .iso_sel, .buffer_status_flags(stat_flags),
    .host_cpu_interrupt_flags(irq_flags));
  hbp_checker hbp_checker_i (.sys_clk, .rst, .cmd_valid(hbp_if_i.cmd_valid),
    .cmd_ready(hbp_if_i.cmd_ready), .cmd(hbp_if_i.cmd), .wr_valid(hbp_if_i.wr_valid),
    .wr_ready(hbp_if_i.wr_ready), .wr_data(hbp_if_i.wr_data),
    .rd_valid(hbp_if_i.rd_valid), .rd_ready(hbp_if_i.rd_ready), .rd_data(hbp_if_i.rd_data));
  // clock and watchdog
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    test_done();
  end
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  // handshakes are judged on values settled before the edge that takes them
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
    logic aw_hit;
    logic w_hit;
    logic b_hit;
    @(posedge sys_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      #1;
      aw_hit = awvalid && awready;
      w_hit  = wvalid && wready;
      b_hit  = (bvalid === 1'b1);
      @(posedge sys_clk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
    end while (!b_hit);
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hit;
    logic r_hit;
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      #1;
      ar_hit = arvalid && arready;
      r_hit  = (rvalid === 1'b1);
      d      = rdata;
      r      = rresp;
      @(posedge sys_clk);
      if (ar_hit) arvalid <= 1'b0;
    end while (!r_hit);
    rready <= 1'b0;
  endtask
  // wait until a word is waiting, then pop it
  task automatic get_word(output logic [31:0] w);
    logic [31:0] s;
    logic [1:0]  r;
    do axi_rd(`HBP_AXI_STAT, s, r); while (s[2] !== 1'b1);
    axi_rd(`HBP_AXI_RDATA, w, r);
  endtask
  task automatic cmd_word(input logic [7:0] c, output logic [31:0] w);
    axi_wr(`HBP_AXI_CMD, {24'h0, c});
    get_word(w);
  endtask
  task automatic test_done();
    if (bad_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] v;
    logic [31:0] len;
    logic [1:0]  r;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    cmd_word(`HBP_CMD_ISO0_LEN, len);
    check(32'h6, len);
    cmd_word(`HBP_CMD_ISO1_LEN, v);
    check(32'ha, v);
    // write three words through each port, then read them back
    for (int p = 0; p < 2; p++) begin
      axi_wr(`HBP_AXI_CMD, {24'h0, `HBP_CMD_COUNT_WR});
      axi_wr(`HBP_AXI_WDATA, len);
      axi_wr(`HBP_AXI_CMD, {24'h0, p ? `HBP_CMD_ASYNC_WR : `HBP_CMD_ISO_WR});
      for (int i = 0; i < 3; i++) axi_wr(`HBP_AXI_WDATA, 32'h0000a010 + 32'(p * 256 + i));
      cmd_word(`HBP_CMD_IRQ_RD, v);
      check(32'h1, {31'h0, v[`HBP_EOT_BIT]});
      cmd_word(`HBP_CMD_STATUS_RD, v);
      check(32'h1, {31'h0, v[p ? `HBP_ST_ASYNC_FULL : `HBP_ST_ISO0_FULL]});
      cmd_word(`HBP_CMD_IRQ_RD, v);
      check(32'h0, {31'h0, v[`HBP_EOT_BIT]});
      axi_wr(`HBP_AXI_CMD, {24'h0, `HBP_CMD_COUNT_WR});
      axi_wr(`HBP_AXI_WDATA, len);
      axi_wr(`HBP_AXI_CMD, {24'h0, p ? `HBP_CMD_ASYNC_RD : `HBP_CMD_ISO_RD});
      for (int i = 0; i < 3; i++) begin
        get_word(v);
        check(32'h0000a010 + 32'(p * 256 + i), v);
      end
    end
    // both buffers read back: done flags up, full flags down, end event pending
    check(32'h28, {26'h0, stat_flags});
    check(32'h1, {31'h0, irq_flags[`HBP_EOT_BIT]});
    // unmapped address answers with an error and no data
    axi_rd(5'h10, v, r);
    check(32'h0, v);
    check(32'h2, {30'h0, r});
    test_done();
  end
endmodule
